// ### rtl/fcsm_params.svh
// constants for the flash command state machine
`ifndef FCSM_PARAMS_SVH
`define FCSM_PARAMS_SVH
`define FCSM_CMD_READ_ARRAY 8'hff
`define FCSM_CMD_WORD_PGM_A 8'h10
`define FCSM_CMD_WORD_PGM_B 8'h40
`define FCSM_CMD_BUF_PGM 8'he8
`define FCSM_CMD_ERASE 8'h20
`define FCSM_CMD_FACTORY_PGM 8'h80
`define FCSM_CMD_CONFIRM 8'hd0
`define FCSM_CMD_SUSPEND 8'hb0
`define FCSM_CMD_READ_STATUS 8'h70
`define FCSM_CMD_CLEAR_STATUS 8'h50
`define FCSM_CMD_READ_ID 8'h90
`define FCSM_CMD_READ_QUERY 8'h98
`define FCSM_CMD_LOCK_SETUP 8'h60
`define FCSM_CMD_LOCK_BLOCK 8'h01
`define FCSM_CMD_LOCK_DOWN 8'h2f
`define FCSM_CMD_CFG_CONFIRM 8'h03
`define FCSM_NUM_PART 4
`define FCSM_PART_W 2
`define FCSM_STATUS_RESET 8'h80
`define FCSM_SR_READY 7
`define FCSM_SR_ERASE_ERR 5
`define FCSM_SR_PGM_ERR 4
`define FCSM_SR_PGM_SUSP 2
`endif

// ### rtl/fcsm_pkg.sv
// types shared by the flash command state machine files
package fcsm_pkg;
  // command state machine states
  typedef enum logic [3:0]
  {
    FCSM_READY = 4'h0,
    FCSM_LOCK_SETUP = 4'h1,
    FCSM_PGM_SETUP = 4'h2,
    FCSM_PGM_BUSY = 4'h3,
    FCSM_PGM_SUSP = 4'h4,
    FCSM_BUF_SETUP = 4'h5,
    FCSM_BUF_LOAD1 = 4'h6,
    FCSM_BUF_LOAD2 = 4'h7,
    FCSM_BUF_BUSY = 4'h8,
    FCSM_ERASE_SETUP = 4'h9,
    FCSM_ERASE_BUSY = 4'ha,
    FCSM_FACT_SETUP = 4'hb
  } fcsm_state_e;
  // per-partition read output mode
  typedef enum logic [1:0]
  {
    FCSM_RD_ARRAY = 2'h0,
    FCSM_RD_ID = 2'h1,
    FCSM_RD_QUERY = 2'h2,
    FCSM_RD_STATUS = 2'h3
  } fcsm_rdmode_e;
endpackage

// ### rtl/fcsm_mode_if.sv
// carrier between the state machine and the read mode table
`timescale 1ns/1ps
interface fcsm_mode_if;
  logic wr_valid; // one-cycle write of a new mode
  logic [1:0] wr_part; // partition written
  fcsm_pkg::fcsm_rdmode_e wr_mode; // mode to store
  logic [7:0] modes; // all partition modes, two bits each
  modport ctrl (output wr_valid, output wr_part, output wr_mode, input modes);
  modport table_side (input wr_valid, input wr_part, input wr_mode, output modes);
endinterface

// ### rtl/fcsm_mode_table.sv
// per-partition read output mode storage
`timescale 1ns/1ps
`include "fcsm_params.svh"
module fcsm_mode_table
(
  input wire logic core_clk,
  input wire logic rst,
  fcsm_mode_if.table_side mif
);
  genvar gi;
  generate
    for (gi = 0; gi < `FCSM_NUM_PART; gi = gi + 1)
    begin : g_part
      fcsm_pkg::fcsm_rdmode_e mode_reg; // held until a new command changes it
      always_ff @(posedge core_clk)
      begin
        if (rst)
          mode_reg <= fcsm_pkg::FCSM_RD_ARRAY;
        else if (mif.wr_valid && (mif.wr_part == 2'(gi)))
          mode_reg <= mif.wr_mode;
      end
      assign mif.modes[2*gi +: 2] = mode_reg;
    end
  endgenerate
endmodule

// ### rtl/fcsm_top.sv
// flash command state machine: command decode, busy and suspend tracking
`timescale 1ns/1ps
`include "fcsm_params.svh"
module fcsm_top
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic [1:0] cmd_part,
  input wire logic op_done,
  input wire logic buf_load_done,
  output logic [7:0] status_reg,
  output logic [3:0] state_out_reg,
  output logic op_active_reg,
  output logic [1:0] op_part_reg,
  output logic lock_error_reg,
  output logic [7:0] read_modes_reg
);
  fcsm_mode_if mif ();
  fcsm_pkg::fcsm_state_e state_reg; // current command state
  fcsm_pkg::fcsm_state_e state_next; // decoded next state
  logic start_op; // an erase, factory or buffer confirm, or the program data byte, launches an array operation
  logic lock_bad; // lock setup saw an invalid confirm
  logic seq_err; // erase or factory setup, or the second buffer load state once buf_load_done is high, saw a non-confirm byte

  fcsm_mode_table u_modes
  (
    .core_clk(core_clk),
    .rst(rst),
    .mif(mif)
  );

  // decode of command bytes that change the read mode; clear status in ready also clears the error bits
  function automatic logic is_read_cmd(input logic [7:0] c);
    is_read_cmd = (c == `FCSM_CMD_READ_ARRAY) || (c == `FCSM_CMD_READ_STATUS) ||
                  (c == `FCSM_CMD_CLEAR_STATUS) || (c == `FCSM_CMD_READ_ID) ||
                  (c == `FCSM_CMD_READ_QUERY);
  endfunction

  // next state decode; read modes are never consulted here
  always_comb
  begin
    state_next = state_reg;
    start_op = 1'b0;
    lock_bad = 1'b0;
    seq_err = 1'b0;
    if (cmd_valid)
    begin
      case (state_reg)
        fcsm_pkg::FCSM_READY:
        begin
          if (cmd_data == `FCSM_CMD_WORD_PGM_A || cmd_data == `FCSM_CMD_WORD_PGM_B)
            state_next = fcsm_pkg::FCSM_PGM_SETUP;
          else if (cmd_data == `FCSM_CMD_BUF_PGM)
            state_next = fcsm_pkg::FCSM_BUF_SETUP;
          else if (cmd_data == `FCSM_CMD_ERASE)
            state_next = fcsm_pkg::FCSM_ERASE_SETUP;
          else if (cmd_data == `FCSM_CMD_FACTORY_PGM)
            state_next = fcsm_pkg::FCSM_FACT_SETUP;
          else if (cmd_data == `FCSM_CMD_LOCK_SETUP)
            state_next = fcsm_pkg::FCSM_LOCK_SETUP;
          else
            state_next = fcsm_pkg::FCSM_READY;
        end
        fcsm_pkg::FCSM_LOCK_SETUP:
        begin
          state_next = fcsm_pkg::FCSM_READY;
          lock_bad = !(cmd_data == `FCSM_CMD_LOCK_BLOCK || cmd_data == `FCSM_CMD_CONFIRM ||
                       cmd_data == `FCSM_CMD_LOCK_DOWN || cmd_data == `FCSM_CMD_CFG_CONFIRM);
        end
        fcsm_pkg::FCSM_PGM_SETUP:
        begin
          // the byte written here is program data, so programming starts
          state_next = fcsm_pkg::FCSM_PGM_BUSY;
          start_op = 1'b1;
        end
        fcsm_pkg::FCSM_PGM_BUSY:
        begin
          if (cmd_data == `FCSM_CMD_SUSPEND)
            state_next = fcsm_pkg::FCSM_PGM_SUSP;
        end
        fcsm_pkg::FCSM_PGM_SUSP:
        begin
          if (cmd_data == `FCSM_CMD_CONFIRM)
            state_next = fcsm_pkg::FCSM_PGM_BUSY;
        end
        fcsm_pkg::FCSM_BUF_SETUP:
          state_next = fcsm_pkg::FCSM_BUF_LOAD1;
        fcsm_pkg::FCSM_BUF_LOAD1:
          state_next = fcsm_pkg::FCSM_BUF_LOAD2;
        fcsm_pkg::FCSM_BUF_LOAD2:
        begin
          if (buf_load_done)
          begin
            if (cmd_data == `FCSM_CMD_CONFIRM)
            begin
              state_next = fcsm_pkg::FCSM_BUF_BUSY;
              start_op = 1'b1;
            end
            else
            begin
              state_next = fcsm_pkg::FCSM_READY;
              seq_err = 1'b1;
            end
          end
        end
        fcsm_pkg::FCSM_ERASE_SETUP, fcsm_pkg::FCSM_FACT_SETUP:
        begin
          if (cmd_data == `FCSM_CMD_CONFIRM)
          begin
            state_next = (state_reg == fcsm_pkg::FCSM_ERASE_SETUP) ?
                         fcsm_pkg::FCSM_ERASE_BUSY : fcsm_pkg::FCSM_BUF_BUSY;
            start_op = 1'b1;
          end
          else
          begin
            state_next = fcsm_pkg::FCSM_READY;
            seq_err = 1'b1;
          end
        end
        default:
          // busy states without suspend support ignore writes
          state_next = state_reg;
      endcase
    end
    // completion of the array operation, unless suspended
    if (op_done && (state_reg == fcsm_pkg::FCSM_PGM_BUSY || state_reg == fcsm_pkg::FCSM_BUF_BUSY ||
                    state_reg == fcsm_pkg::FCSM_ERASE_BUSY) && state_next != fcsm_pkg::FCSM_PGM_SUSP)
      state_next = fcsm_pkg::FCSM_READY;
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_reg <= fcsm_pkg::FCSM_READY;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      op_active_reg <= 1'b0;
      op_part_reg <= 2'h0;
    end
    else if (start_op && !op_active_reg)
    begin
      op_active_reg <= 1'b1;
      op_part_reg <= cmd_part;
    end
    else if (state_next == fcsm_pkg::FCSM_READY)
      op_active_reg <= 1'b0;
  end

  // status register; error bits are sticky until clear status
  always_ff @(posedge core_clk)
  begin
    if (rst)
      status_reg <= `FCSM_STATUS_RESET;
    else
    begin
      status_reg[`FCSM_SR_READY] <= !(state_next == fcsm_pkg::FCSM_PGM_BUSY ||
                                      state_next == fcsm_pkg::FCSM_BUF_BUSY ||
                                      state_next == fcsm_pkg::FCSM_ERASE_BUSY);
      status_reg[`FCSM_SR_PGM_SUSP] <= (state_next == fcsm_pkg::FCSM_PGM_SUSP);
      // set wins over clear: a clear in ready never coincides with an error set
      if (cmd_valid && state_reg == fcsm_pkg::FCSM_READY && cmd_data == `FCSM_CMD_CLEAR_STATUS)
      begin
        status_reg[`FCSM_SR_ERASE_ERR] <= 1'b0;
        status_reg[`FCSM_SR_PGM_ERR] <= 1'b0;
      end
      if (lock_bad || seq_err)
      begin
        status_reg[`FCSM_SR_ERASE_ERR] <= 1'b1;
        status_reg[`FCSM_SR_PGM_ERR] <= 1'b1;
      end
    end
  end

  // lock error pulse
  always_ff @(posedge core_clk)
  begin
    if (rst)
      lock_error_reg <= 1'b0;
    else
      lock_error_reg <= lock_bad;
  end

  always_comb
  begin
    mif.wr_valid = cmd_valid;
    mif.wr_part = cmd_part;
    mif.wr_mode = fcsm_pkg::FCSM_RD_STATUS;
    if (cmd_data == `FCSM_CMD_READ_ARRAY)
      mif.wr_mode = fcsm_pkg::FCSM_RD_ARRAY;
    else if (cmd_data == `FCSM_CMD_READ_ID)
      mif.wr_mode = fcsm_pkg::FCSM_RD_ID;
    else if (cmd_data == `FCSM_CMD_READ_QUERY)
      mif.wr_mode = fcsm_pkg::FCSM_RD_QUERY;
    else if (state_reg == fcsm_pkg::FCSM_READY && is_read_cmd(cmd_data))
      mif.wr_mode = fcsm_pkg::FCSM_RD_STATUS;
    else if (cmd_data == `FCSM_CMD_CLEAR_STATUS)
      mif.wr_valid = 1'b0;
  end

  // registered copies of state and modes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // reset copies follow the reset state and array read mode everywhere
      state_out_reg <= fcsm_pkg::FCSM_READY;
      read_modes_reg <= {`FCSM_NUM_PART{fcsm_pkg::FCSM_RD_ARRAY}};
    end
    else
    begin
      state_out_reg <= state_next;
      read_modes_reg <= mif.modes;
    end
  end
endmodule

// ### verification/fcsm_host.sv
// host model: writes command bytes to the state machine
`timescale 1ns/1ps
module fcsm_host
(
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic [1:0] cmd_part
);
  // quiet bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_part = 2'h0;
  end
  // one write, held for exactly one rising edge
  // the released byte is inverted so stale data never looks valid
  task automatic send(input logic [7:0] b, input logic [1:0] p);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_data = b;
    cmd_part = p;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_data = ~b;
  endtask
  task automatic buf_fill(input logic [7:0] n, input logic [1:0] p);
    send(8'he8, p);
    send(n, p);
    repeat (n) send(8'h5a, p);
  endtask
endmodule

// ### verification/fcsm_top_asserts.sv
// concurrent checks on the state machine ports
`timescale 1ns/1ps
module fcsm_top_asserts
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic [1:0] cmd_part,
  input wire logic op_done,
  input wire logic buf_load_done,
  input wire logic [7:0] status_reg,
  input wire logic [3:0] state_out_reg,
  input wire logic op_active_reg,
  input wire logic [1:0] op_part_reg,
  input wire logic lock_error_reg,
  input wire logic [7:0] read_modes_reg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_busy_low_status: assert property (state_out_reg == fcsm_pkg::FCSM_PGM_BUSY |-> !status_reg[7])
    else $error("ready bit high while busy");
  a_ready_pgm_decode: assert property (cmd_valid && cmd_data == 8'h40 && state_out_reg == fcsm_pkg::FCSM_READY
    |=> state_out_reg == fcsm_pkg::FCSM_PGM_SETUP) else $error("program byte not decoded");
  a_ready_stays_put: assert property (cmd_valid && state_out_reg == fcsm_pkg::FCSM_READY
    && cmd_data inside {8'hff, 8'h70, 8'h50, 8'h90, 8'h98, 8'hd0, 8'hb0} |=> state_out_reg == fcsm_pkg::FCSM_READY)
    else $error("left ready on a read byte");
  a_lock_bad_err: assert property (state_out_reg == fcsm_pkg::FCSM_LOCK_SETUP && cmd_valid
    && !(cmd_data inside {8'h01, 8'hd0, 8'h2f, 8'h03}) |=> lock_error_reg && state_out_reg == fcsm_pkg::FCSM_READY)
    else $error("bad lock byte not flagged");
  a_susp_enter: assert property (state_out_reg == fcsm_pkg::FCSM_PGM_BUSY && cmd_valid && cmd_data == 8'hb0
    && !op_done |=> state_out_reg == fcsm_pkg::FCSM_PGM_SUSP && status_reg[2]) else $error("suspend not entered");
  a_resume_busy: assert property (state_out_reg == fcsm_pkg::FCSM_PGM_SUSP && cmd_valid && cmd_data == 8'hd0
    |=> state_out_reg == fcsm_pkg::FCSM_PGM_BUSY) else $error("resume not taken");
  a_busy_ignores: assert property (state_out_reg == fcsm_pkg::FCSM_PGM_BUSY && cmd_valid && cmd_data != 8'hb0
    && !op_done |=> state_out_reg == fcsm_pkg::FCSM_PGM_BUSY) else $error("busy left on other byte");
  a_one_owner: assert property (op_active_reg && $past(op_active_reg) |-> op_part_reg == $past(op_part_reg))
    else $error("owner changed during operation");
  a_mode_id_kept: assert property (cmd_valid && cmd_data == 8'h90 && cmd_part == 2'h1
    |-> ##2 read_modes_reg[3:2] == 2'h1) else $error("identifier mode not stored");
  a_buf_load_one: assert property (state_out_reg == fcsm_pkg::FCSM_BUF_SETUP && cmd_valid
    |=> state_out_reg == fcsm_pkg::FCSM_BUF_LOAD1) else $error("buffer setup did not go to load1");
  c_suspend: cover property (state_out_reg == fcsm_pkg::FCSM_PGM_SUSP);
  c_lock_err: cover property (lock_error_reg);
  c_buf_busy: cover property (state_out_reg == fcsm_pkg::FCSM_BUF_BUSY);
endmodule
bind fcsm_top fcsm_top_asserts i_chk (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
  .cmd_part(cmd_part), .op_done(op_done), .buf_load_done(buf_load_done), .status_reg(status_reg),
  .state_out_reg(state_out_reg), .op_active_reg(op_active_reg), .op_part_reg(op_part_reg),
  .lock_error_reg(lock_error_reg), .read_modes_reg(read_modes_reg));

// ### verification/fcsm_top_test.sv
// self-checking bench for the flash command state machine
`timescale 1ns/1ps
module fcsm_top_test;
  logic core_clk = 1'b0; // 40 MHz
  logic rst = 1'b1; // held at start
  logic op_done = 1'b0;
  logic buf_load_done = 1'b0;
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic [1:0] cmd_part;
  logic [7:0] status_reg;
  logic [3:0] state_out_reg;
  logic op_active_reg;
  logic [1:0] op_part_reg;
  logic lock_error_reg;
  logic [7:0] read_modes_reg;
  int fail_count = 0;
  int n_tests = 0;
  // bytes from ready and the state each should reach
  logic [7:0] row_cmd [13] = '{8'h10, 8'h40, 8'he8, 8'h20, 8'h80, 8'h60, 8'hff, 8'h70, 8'h50, 8'h90, 8'h98,
    8'hd0, 8'hb0};
  logic [3:0] row_st [13] = '{4'h2, 4'h2, 4'h5, 4'h9, 4'hb, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  always #12.5 core_clk = ~core_clk;
  fcsm_host i_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_part(cmd_part));
  fcsm_top i_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_part(cmd_part),
    .op_done(op_done), .buf_load_done(buf_load_done), .status_reg(status_reg), .state_out_reg(state_out_reg),
    .op_active_reg(op_active_reg), .op_part_reg(op_part_reg), .lock_error_reg(lock_error_reg),
    .read_modes_reg(read_modes_reg));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
  endtask
  // one-cycle completion pulse from the array engine
  task automatic finish_op();
    @(negedge core_clk);
    op_done = 1'b1;
    @(negedge core_clk);
    op_done = 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well beyond the roughly 120 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    do_reset();
    chk("reset status", 8'h80, status_reg); // status default
    for (int i = 0; i < 13; i++)
    begin
      do_reset();
      i_host.send(row_cmd[i], 2'h0);
      chk("ready next", {4'h0, row_st[i]}, {4'h0, state_out_reg}); // ready decode
    end
    $display("test ready table done");
    do_reset();
    i_host.send(8'h40, 2'h1);
    i_host.send(8'h12, 2'h1);
    chk("busy state", 8'h03, {4'h0, state_out_reg}); // program busy
    chk("busy bit", 8'h00, {7'h0, status_reg[7]}); // busy status
    chk("active", 8'h01, {7'h0, op_active_reg}); // operation owns array
    i_host.send(8'h40, 2'h3);
    chk("owner", 8'h01, {6'h0, op_part_reg}); // single owner
    i_host.send(8'hb0, 2'h1);
    chk("susp state", 8'h04, {4'h0, state_out_reg}); // suspend entered
    chk("susp bit", 8'h01, {7'h0, status_reg[2]}); // suspend flag
    i_host.send(8'h70, 2'h1);
    chk("susp hold", 8'h04, {4'h0, state_out_reg}); // other byte ignored
    i_host.send(8'hd0, 2'h1);
    chk("resume", 8'h03, {4'h0, state_out_reg}); // resume to busy
    finish_op();
    chk("done state", 8'h00, {4'h0, state_out_reg}); // back to ready
    chk("ready bit", 8'h01, {7'h0, status_reg[7]}); // ready status
    $display("test word program done");
    do_reset();
    i_host.send(8'h60, 2'h0);
    i_host.send(8'h55, 2'h0);
    chk("lock err", 8'h01, {7'h0, lock_error_reg}); // error pulse
    chk("lock state", 8'h00, {4'h0, state_out_reg}); // back to ready
    chk("err bits", 8'h03, {6'h0, status_reg[5:4]}); // error flags
    i_host.send(8'h60, 2'h0);
    i_host.send(8'h01, 2'h0);
    chk("lock ok", 8'h00, {7'h0, lock_error_reg}); // valid lock no error
    $display("test lock done");
    do_reset();
    i_host.send(8'h90, 2'h1);
    @(negedge core_clk);
    i_host.send(8'h98, 2'h2);
    @(negedge core_clk);
    chk("modes", 8'h24, read_modes_reg); // modes per partition
    i_host.send(8'h40, 2'h1);
    chk("mode free", 8'h02, {4'h0, state_out_reg}); // mode does not steer
    $display("test read modes done");
    do_reset();
    i_host.buf_fill(8'h02, 2'h0);
    chk("load2", 8'h07, {4'h0, state_out_reg}); // load stages
    buf_load_done = 1'b1;
    i_host.send(8'hd0, 2'h0);
    chk("buf busy", 8'h08, {4'h0, state_out_reg}); // confirm after fill
    buf_load_done = 1'b0;
    finish_op();
    chk("buf done", 8'h00, {4'h0, state_out_reg}); // back to ready
    $display("test buffer done");
    do_reset();
    i_host.send(8'h20, 2'h2);
    i_host.send(8'hd0, 2'h2);
    chk("erase busy", 8'h0a, {4'h0, state_out_reg}); // erase confirmed
    chk("erase bit", 8'h00, {7'h0, status_reg[7]}); // busy status
    chk("erase owner", 8'h02, {6'h0, op_part_reg}); // owner partition
    finish_op();
    chk("erase idle", 8'h00, {7'h0, op_active_reg}); // owner released
    i_host.send(8'h80, 2'h0);
    i_host.send(8'h12, 2'h0);
    chk("fact abort", 8'h00, {4'h0, state_out_reg}); // bad factory confirm
    chk("seq err", 8'h03, {6'h0, status_reg[5:4]}); // error flags
    i_host.send(8'h50, 2'h0);
    chk("err clear", 8'h00, {6'h0, status_reg[5:4]}); // clear status in ready
    $display("test erase done");
    give_verdict();
  end
endmodule
